// ===== rtl/crb_pkg.sv
// Purpose: Constants for the CAN receive buffer control block
// Assumes: 8-bit register port, one clock domain
// Notes:   Offsets index a byte-wide register file
//
// Behaviour
// - Storing a received message into a buffer sets that buffer's full flag.
// - A buffer whose full flag is set is never loaded with a new message.
// - Clearing buffer 0 interrupt flag while buffer 0 stays full sets it again.
// - Legacy mode 11 accepts every message, errors included, ignoring filters.
// - Legacy mode 10 accepts valid extended messages through extended-enabled filters.
// - Legacy mode 01 accepts valid standard messages through standard filters.
// - Legacy mode 00 accepts valid messages typed by each filter's extended enable.
// - Enhanced mode bit 1 accepts everything; 0 accepts valid filter-passed messages.
// - Read-only remote request bit at bit 3 legacy, bit 5 enhanced.
// - Legacy double-buffer enable at bit 2 sends buffer 0 overflow to buffer 1.
// - Legacy buffer 0 bit 1 reads back a copy of the double-buffer enable.
// - Legacy buffer 0 bit 0 tells whether filter 1 or filter 0 accepted.
// - Enhanced modes report the accepting filter as a five-bit index.
// - Legacy buffer 1 reports a three-bit filter index, 2 to 5 normally.
// - Buffer 1 index 0 or 1 arises through double-buffer overflow, or when buffer 1 is in mode 11.
// - Legacy bit 4 of both control registers reads zero.
package crb_pkg;
  // Register offsets
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h1;
  localparam logic [3:0] OFS_IRQST = 4'h2;
  localparam logic [3:0] OFS_IRQMK = 4'h3;
  // Control register bit positions
  localparam int BIT_FULL  = 7;
  localparam int BIT_MODE1 = 6;
  localparam int BIT_MODE0 = 5;
  localparam int BIT_DBEN  = 2;
  // Interrupt status bit positions
  localparam int IRQ_BUF0  = 0;
  localparam int IRQ_BUF1  = 1;
  localparam int IRQ_LOST  = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ  = 3'h0;
  // Legacy receive mode codes
  localparam logic [1:0] RXM_ALL = 2'h3;
  localparam logic [1:0] RXM_EXT = 2'h2;
  localparam logic [1:0] RXM_STD = 2'h1;
  localparam logic [1:0] RXM_ANY = 2'h0;
  // Functional mode of the CAN module
  typedef enum logic [1:0] {
    FM_LEGACY = 2'b00,
    FM_ENH1   = 2'b01,
    FM_ENH2   = 2'b10,
    FM_RSVD   = 2'b11
  } crb_fmode_t;
  // Per-buffer stored state
  typedef struct packed {
    logic       full;
    logic [1:0] rxm;
    logic       remote;
    logic [4:0] hit;
  } crb_buf_t;
endpackage

// ===== rtl/crb_rx_buffer_control.sv
// Purpose: Control and status of the two dedicated CAN receive buffers
// Assumes: Frame inputs come from the protocol engine on the same clock
// Notes:   Message contents are stored elsewhere on the load pulses
`timescale 1ns/100ps
`default_nettype none
module crb_rx_buffer_control (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output var  logic [7:0]        regRdData,
  input  wire crb_pkg::crb_fmode_t funcMode,
  input  wire logic              frameValid,
  input  wire logic              frameError,
  input  wire logic              frameExtended,
  input  wire logic              frameRemote,
  input  wire logic              filterMatch,
  input  wire logic [4:0]        filterHitIdx,
  input  wire logic              filterExtIdEnable,
  output var  logic              loadBuffer0,
  output var  logic              loadBuffer1,
  output var  logic              irq
);
  import crb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    crb_buf_t   buf0;
    crb_buf_t   buf1;
    logic       doubleBufferEnable;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic [7:0] rdData;
    logic       load0;
    logic       load1;
    logic       irqOut;
  } crb_state_t;

  crb_state_t st;
  crb_state_t next_st;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Acceptance test of one buffer for the incoming frame
  function automatic logic acceptFrame(input logic legacy, input logic [1:0] rxm,
                                       input logic err, input logic ext,
                                       input logic match, input logic filtExt);
    logic ok;
    ok = 1'b0;
    if (legacy) begin
      case (rxm)
        RXM_ALL: ok = 1'b1;
        RXM_EXT: ok = !err && match && ext && filtExt;
        RXM_STD: ok = !err && match && !ext && !filtExt;
        RXM_ANY: ok = !err && match && (ext == filtExt);
        default: ok = 1'b0;
      endcase
    end else begin
      ok = rxm[1] ? 1'b1 : (!err && match);
    end
    return ok;
  endfunction

  // Read view of one control register in the current mode
  function automatic logic [7:0] ctrlView(input logic legacy, input crb_buf_t b,
                                          input logic isBuf0, input logic dben);
    logic [7:0] v;
    v = RST_BYTE;
    if (legacy) begin
      v[BIT_FULL]  = b.full;
      v[BIT_MODE1] = b.rxm[1];
      v[BIT_MODE0] = b.rxm[0];
      v[4]         = 1'b0;
      v[3]         = b.remote;
      if (isBuf0) begin
        v[BIT_DBEN] = dben;
        v[1]        = dben;
        v[0]        = b.hit[0];
      end else begin
        v[2:0]      = b.hit[2:0];
      end
    end else begin
      v[BIT_FULL]  = b.full;
      v[BIT_MODE1] = b.rxm[1];
      v[5]         = b.remote;
      v[4:0]       = b.hit;
    end
    return v;
  endfunction

  // Software write to a control register: mode bits, full cleared only
  function automatic crb_buf_t ctrlWrite(input logic legacy, input crb_buf_t b,
                                         input logic [7:0] d);
    crb_buf_t r;
    r = b;
    r.rxm[1] = d[BIT_MODE1];
    if (legacy) begin
      r.rxm[0] = d[BIT_MODE0];
    end
    if (!d[BIT_FULL]) begin
      r.full = 1'b0;
    end
    return r;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic legacyMode;
  logic accept0;
  logic accept1;
  logic want0;
  logic want1;
  logic spill;
  logic take0;
  logic take1;
  logic lost;
  logic wrCtrl0;
  logic wrCtrl1;
  logic wrClr;
  logic wrMask;
  logic [2:0] clrBits;
  logic [2:0] events;
  crb_buf_t   newMsg;

  // Decode, route, flag update and register port
  always_comb begin
    next_st = st;
    // Legacy decoding only in mode 0; stored flags untouched on change
    legacyMode = (funcMode == FM_LEGACY);
    accept0 = acceptFrame(legacyMode, st.buf0.rxm, frameError, frameExtended,
                          filterMatch, filterExtIdEnable);
    accept1 = acceptFrame(legacyMode, st.buf1.rxm, frameError, frameExtended,
                          filterMatch, filterExtIdEnable);
    // Legacy: filters 0 and 1 feed buffer 0, filters 2 to 5 buffer 1
    want0 = frameValid && accept0 &&
            (!legacyMode || st.buf0.rxm == RXM_ALL || filterHitIdx < 5'h02);
    want1 = frameValid && accept1 &&
            (!legacyMode || st.buf1.rxm == RXM_ALL ||
             (filterHitIdx >= 5'h02 && filterHitIdx <= 5'h05));
    // Overflow path into buffer 1 when buffer 0 is occupied
    spill = want0 && st.buf0.full && legacyMode && st.doubleBufferEnable;
    take0 = want0 && !st.buf0.full;
    take1 = !take0 && (want1 || spill) && !st.buf1.full;
    lost  = frameValid && (want0 || want1) && !take0 && !take1;
    newMsg.full   = 1'b1;
    newMsg.rxm    = 2'h0;
    newMsg.remote = frameRemote;
    newMsg.hit    = filterHitIdx;
    // Register strobes
    wrCtrl0 = regWrite && regAddr == OFS_CTRL0;
    wrCtrl1 = regWrite && regAddr == OFS_CTRL1;
    wrClr   = regWrite && regAddr == OFS_IRQST;
    wrMask  = regWrite && regAddr == OFS_IRQMK;
    clrBits = wrClr ? regWrData[2:0] : 3'h0;
    // Software writes first, hardware set afterwards so set wins
    if (wrCtrl0) begin
      next_st.buf0 = ctrlWrite(legacyMode, st.buf0, regWrData);
      if (legacyMode) begin
        next_st.doubleBufferEnable = regWrData[BIT_DBEN];
      end
    end
    if (wrCtrl1) begin
      next_st.buf1 = ctrlWrite(legacyMode, st.buf1, regWrData);
    end
    if (wrMask) begin
      next_st.irqMask = regWrData[2:0];
    end
    if (take0) begin
      newMsg.rxm   = next_st.buf0.rxm;
      next_st.buf0 = newMsg;
    end
    if (take1) begin
      newMsg.rxm   = next_st.buf1.rxm;
      next_st.buf1 = newMsg;
    end
    // Sticky events, write one to clear, set wins
    events = 3'h0;
    events[IRQ_BUF0] = take0;
    events[IRQ_BUF1] = take1;
    events[IRQ_LOST] = lost;
    next_st.irqStatus = (st.irqStatus & ~clrBits) | events;
    // Buffer 0 flag returns while buffer 0 still holds a message
    if (clrBits[IRQ_BUF0] && next_st.buf0.full) begin
      next_st.irqStatus[IRQ_BUF0] = 1'b1;
    end
    // Read data one cycle after the strobe, zero for unmapped
    next_st.rdData = RST_BYTE;
    if (regRead) begin
      case (regAddr)
        OFS_CTRL0: next_st.rdData = ctrlView(legacyMode, st.buf0, 1'b1,
                                             st.doubleBufferEnable);
        OFS_CTRL1: next_st.rdData = ctrlView(legacyMode, st.buf1, 1'b0,
                                             st.doubleBufferEnable);
        OFS_IRQST: next_st.rdData = {5'h00, st.irqStatus};
        OFS_IRQMK: next_st.rdData = {5'h00, st.irqMask};
        default:   next_st.rdData = RST_BYTE;
      endcase
    end
    next_st.load0  = take0;
    next_st.load1  = take1;
    next_st.irqOut = |(next_st.irqStatus & next_st.irqMask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset to all zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st.buf0               <= '0;
      st.buf1               <= '0;
      st.doubleBufferEnable <= 1'b0;
      st.irqStatus          <= RST_IRQ;
      st.irqMask            <= RST_IRQ;
      st.rdData             <= RST_BYTE;
      st.load0              <= 1'b0;
      st.load1              <= 1'b0;
      st.irqOut             <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign regRdData   = st.rdData;
  assign loadBuffer0 = st.load0;
  assign loadBuffer1 = st.load1;
  assign irq         = st.irqOut;
endmodule
`default_nettype wire

// ===== dv/crb_properties.sv
// Purpose: Port checks for the receive buffer control block
// Assumes: One clock, synchronous reset
// Notes:   Full flags are shadowed from load pulses and writes
`timescale 1ns/100ps
`default_nettype none
module crb_properties (
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic [3:0]         regAddr,
  input wire logic [7:0]         regWrData,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [7:0]         regRdData,
  input wire crb_pkg::crb_fmode_t funcMode,
  input wire logic               frameValid,
  input wire logic               loadBuffer0,
  input wire logic               loadBuffer1,
  input wire logic               irq
);
  import crb_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic full0, full1, mask0;
  logic rdLeg;
  // ****
  // Shadow state, a clearing write beats a load pulse
  // ****
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {full0, full1, mask0} <= 3'h0;
    end else begin
      if (regWrite && regAddr == OFS_CTRL0 && !regWrData[BIT_FULL]) full0 <= 1'b0;
      else if (loadBuffer0) full0 <= 1'b1;
      if (regWrite && regAddr == OFS_CTRL1 && !regWrData[BIT_FULL]) full1 <= 1'b0;
      else if (loadBuffer1) full1 <= 1'b1;
      if (regWrite && regAddr == OFS_IRQMK) mask0 <= regWrData[IRQ_BUF0];
    end
  end
  assign rdLeg = regRead && funcMode == FM_LEGACY;
  a_load_cause: assert property ((loadBuffer0 || loadBuffer1) |-> $past(frameValid))
    else $error("load pulse without a frame");
  a_one_target: assert property (!(loadBuffer0 && loadBuffer1))
    else $error("frame loaded into both buffers");
  a_no_reload0: assert property (loadBuffer0 |-> !$past(full0))
    else $error("buffer 0 loaded while full");
  a_no_reload1: assert property (loadBuffer1 |-> !$past(full1))
    else $error("buffer 1 loaded while full");
  a_full_read: assert property ($past(regRead && regAddr == OFS_CTRL0 && full0) && full0
    |-> regRdData[BIT_FULL])
    else $error("full flag reads low");
  a_irq_hold: assert property (full0 && mask0 && $past(full0 && mask0) |-> irq)
    else $error("interrupt low while buffer 0 full");
  a_bit4_zero: assert property ($past(rdLeg && regAddr <= OFS_CTRL1)
    && funcMode == FM_LEGACY |-> !regRdData[4])
    else $error("legacy bit 4 reads one");
  a_jump_copy: assert property ($past(rdLeg && regAddr == OFS_CTRL0)
    && funcMode == FM_LEGACY |-> regRdData[1] == regRdData[2])
    else $error("jump offset copy differs");
  cover property (loadBuffer1);
  cover property (irq && loadBuffer0);
  cover property (frameValid ##1 !loadBuffer0 && !loadBuffer1);
endmodule
bind crb_rx_buffer_control crb_properties crb_properties_i (.clock, .sys_rst, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .funcMode, .frameValid, .loadBuffer0,
  .loadBuffer1, .irq);
`default_nettype wire

// ===== dv/crb_frame_src.sv
// Purpose: Protocol engine model offering received frames
// Assumes: Qualifiers count only beside the frame strobe
// Notes:   Qualifiers are inverted between frames
`timescale 1ns/100ps
`default_nettype none
module crb_frame_src (
  input  wire logic       clock,
  output var  logic       frameValid,
  output var  logic       frameError,
  output var  logic       frameExtended,
  output var  logic       frameRemote,
  output var  logic       filterMatch,
  output var  logic       filterExtIdEnable,
  output var  logic [4:0] filterHitIdx
);
  initial frameValid = 1'b0;
  initial {frameError, frameExtended, frameRemote, filterMatch, filterExtIdEnable} = 5'h00;
  initial filterHitIdx = 5'h00;
  // One frame strobe, q is error, extended, remote, match, filter extended
  task automatic send(input logic [4:0] q, input logic [4:0] h);
    @(posedge clock);
    frameValid <= 1'b1;
    {frameError, frameExtended, frameRemote, filterMatch, filterExtIdEnable} <= q;
    filterHitIdx <= h;
    @(posedge clock);
    frameValid <= 1'b0;
    {frameError, frameExtended, frameRemote, filterMatch, filterExtIdEnable} <= ~q;
    filterHitIdx <= ~h;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_crb_rx_buffer_control.sv
// Purpose: Self-checking bench for the receive buffer control block
// Assumes: Fixed latencies of the register and frame ports
// Notes:   Loads are counted from the pulse outputs
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_crb_rx_buffer_control;
  import crb_pkg::*;
  logic       clock, sys_rst, regWrite, regRead, irq, loadBuffer0, loadBuffer1;
  logic       frameValid, frameError, frameExtended, frameRemote, filterMatch, filterExtIdEnable;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [4:0] filterHitIdx;
  crb_fmode_t funcMode;
  int         n_fail, n_compared, nLoad0, nLoad1;
  logic [6:0] modeTab [8] = '{7'h71, 7'h4F, 7'h44, 7'h25, 7'h2E, 7'h0F, 7'h14, 7'h00};
  crb_rx_buffer_control crb_rx_buffer_control_i (.clock, .sys_rst, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .funcMode, .frameValid, .frameError, .frameExtended,
    .frameRemote, .filterMatch, .filterHitIdx, .filterExtIdEnable, .loadBuffer0,
    .loadBuffer1, .irq);
  crb_frame_src crb_frame_src_i (.clock, .frameValid, .frameError, .frameExtended,
    .frameRemote, .filterMatch, .filterExtIdEnable, .filterHitIdx);
  initial clock = 1'b0;
  always #50 clock = ~clock;
  // Load pulse counters
  always @(posedge clock) begin
    nLoad0 += int'(loadBuffer0);
    nLoad1 += int'(loadBuffer1);
  end
  // ****
  // Bus and frame tasks
  // ****
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    `CHK("regRdData", e, regRdData & m)
  endtask
  task automatic frame(input logic [4:0] q, input logic [4:0] h);
    crb_frame_src_i.send(q, h);
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    wr(4'h9, 8'hFF);
    for (int a = 0; a < 5; a++) rd(4'(a), 8'hFF, 8'h00);
    rd(4'h9, 8'hFF, 8'h00);
    wr(OFS_CTRL0, 8'h80);
    rd(OFS_CTRL0, 8'h80, 8'h00);
  endtask
  task automatic t_fill();
    wr(OFS_IRQMK, 8'h03);
    frame(5'b00110, 5'h01);
    rd(OFS_CTRL0, 8'hFF, 8'h89);
    frame(5'b00010, 5'h00);
    `CHK("loads", 1, nLoad0 + nLoad1)
    wr(OFS_IRQST, 8'h01);
    wr(OFS_CTRL0, 8'h80);
    rd(OFS_CTRL0, 8'h80, 8'h80);
    `CHK("irq", 1'b1, irq)
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_IRQST, 8'h01);
    rd(OFS_IRQST, 8'h03, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_dbuf();
    wr(OFS_CTRL0, 8'h04);
    rd(OFS_CTRL0, 8'h96, 8'h06);
    frame(5'b00010, 5'h00);
    frame(5'b00010, 5'h01);
    rd(OFS_CTRL1, 8'hFF, 8'h81);
    frame(5'b00010, 5'h03);
    `CHK("load1", 1, nLoad1)
    wr(OFS_CTRL1, 8'h00);
    frame(5'b00010, 5'h05);
    rd(OFS_CTRL1, 8'h97, 8'h85);
    wr(OFS_CTRL0, 8'h00);
  endtask
  task automatic t_modes();
    int n;
    for (int i = 0; i < 8; i++) begin
      n = nLoad0;
      wr(OFS_CTRL0, {1'b0, modeTab[i][6:5], 5'h00});
      frame({modeTab[i][4:3], 1'b0, modeTab[i][2:1]}, 5'h00);
      `CHK("load0", int'(modeTab[i][0]), nLoad0 - n)
    end
  endtask
  task automatic t_enh();
    @(posedge clock);
    funcMode <= FM_ENH1;
    wr(OFS_CTRL0, 8'h40);
    frame(5'b10100, 5'h0F);
    rd(OFS_CTRL0, 8'hE0, 8'hE0);
    wr(OFS_CTRL0, 8'h00);
    frame(5'b10110, 5'h0E);
    frame(5'b00000, 5'h0D);
    frame(5'b00010, 5'h0F);
    rd(OFS_CTRL0, 8'hFF, 8'h8F);
    @(posedge clock);
    funcMode <= FM_LEGACY;
    rd(OFS_CTRL0, 8'hFF, 8'h81);
    wr(OFS_IRQMK, 8'h00);
    rd(OFS_IRQMK, 8'hFF, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask
  initial begin
    {sys_rst, regWrite, regRead, regAddr, regWrData} = 15'h4000;
    funcMode = FM_LEGACY;
    {n_fail, n_compared, nLoad0, nLoad1} = '0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_fill();
    t_dbuf();
    t_modes();
    t_enh();
    report_and_stop();
  end
endmodule
`default_nettype wire
